/* logic/sctw_defines.svh */
// sctw_defines.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the serial control block files
`ifndef SCTW_DEFINES_SVH
`define SCTW_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SCTW_OFS_CTRL_ONE 8'h00
`define SCTW_OFS_CTRL_TWO 8'h01
`define SCTW_OFS_STATUS 8'h03
`define SCTW_OFS_DATA_HI 8'h04
`define SCTW_OFS_DATA_LO 8'h05

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SCTW_BIT_MASTER 4
`define SCTW_BIT_SELECT_OUTPUT_ENABLE 1
`define SCTW_BIT_WIDTH 6
`define SCTW_BIT_MODE_FAULT_ENABLE 4
`define SCTW_BIT_BIDIR_OUTPUT_ENABLE 3
`define SCTW_BIT_WAITSTOP 1
`define SCTW_BIT_PINCTL 0
`define SCTW_BIT_DONE 7
`define SCTW_BIT_MODE_FAULT_FLAG 4
`define SCTW_BIT_BUSY 0
`define SCTW_CTRL_TWO_MASK 8'h5b
`define SCTW_CTRL_ONE_MASK 8'h12

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define SCTW_RST_CTRL_ONE 8'h00
`define SCTW_RST_CTRL_TWO 8'h00
`define SCTW_SYNC_STAGES 3
`define SCTW_WIDTH_NARROW 5'h08
`define SCTW_WIDTH_WIDE 5'h10

`endif

/* logic/sctw_pkg.sv */
// sctw_pkg: types shared by the serial control block
// assumes: sctw_defines.svh supplies the numbers
package sctw_pkg;

	// configuration seen by the link side
	typedef struct packed {
		logic master;
		logic mode_fault_enable;
		logic select_output_enable;
		logic width;
		logic pinctl;
		logic bidir_oe;
		logic wait_stop;
		logic wait_mode;
	} cfg_type;

	// pin drive, all from link-side flip-flops
	typedef struct packed {
		logic sck;
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
		logic ss_o;
		logic ss_oe;
	} pin_out_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SHIFT = 2'b10
	} state_type;

endpackage : sctw_pkg

/* logic/sctw_sync.sv */
// sctw_sync: three-stage synchroniser, output follows once stages two and three agree
// assumes: i_d is from another clock domain or a pin
`timescale 1ns/100ps
module sctw_sync #(
	parameter int W = 1
) (
	// clock and reset of the receiving domain
	input wire logic i_clk,
	input wire logic i_rst,
	// data
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
	logic [W-1:0] nxt_q;

	always_comb begin
		nxt_q = q_ff;
		for (int i = 0; i < W; i++) begin
			if (s2_ff[i] == s3_ff[i]) begin
				nxt_q[i] = s3_ff[i];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			q_ff <= '0;
		end else begin
			s1_ff <= i_d;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			q_ff <= nxt_q;
		end
	end

	assign o_q = q_ff;
endmodule : sctw_sync

/* logic/sctw_ctrl.sv */
// sctw_ctrl: second serial control register with width, select-pin, pin-control
// and wait clock stop, plus a small shift engine on the link clock
// assumes: i_link_clk is the serial reference in master mode and the
// incoming serial clock in slave mode; pins are synchronous to it
//
// The plain strobed port and the address map are this design's own decisions.
`include "sctw_defines.svh"
`timescale 1ns/100ps
module sctw_ctrl (
	// bus clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// system state
	input wire logic i_wait_mode,
	// link clock and pins
	input wire logic i_link_clk,
	input wire logic i_miso,
	input wire logic i_mosi,
	input wire logic i_ss_n,
	output sctw_pkg::pin_out_type o_pins
);
	// ------------------------------------------------------------
	// bus domain state
	// ------------------------------------------------------------
	logic [7:0] ctrl_one_ff, nxt_ctrl_one;
	logic [7:0] ctrl_two_ff, nxt_ctrl_two;
	logic [7:0] data_hi_ff, nxt_data_hi;
	logic [7:0] data_lo_ff, nxt_data_lo;
	logic [15:0] tx_ff, nxt_tx;
	logic busy_ff, nxt_busy;
	logic done_flag_ff, nxt_done_flag;
	logic mode_fault_flag_ff, nxt_mode_fault_flag;
	logic start_tgl_ff, nxt_start_tgl;
	logic abort_tgl_ff, nxt_abort_tgl;
	logic done_seen_ff, nxt_done_seen;
	logic [7:0] rdata_ff, nxt_rdata;
	// link-domain done toggle, declared here because the bus side syncs it
	logic done_tgl_lk_ff;
	logic ss_n_bus;
	logic done_tgl_bus;
	logic [15:0] rx_bus;
	sctw_pkg::cfg_type cfg_bus;

	// true when a write to the second control register must end a transfer
	function automatic logic cfg_abort(input logic [7:0] old_v, input logic [7:0] new_v);
		logic base;
		logic oe;
		base = (old_v[`SCTW_BIT_WIDTH] != new_v[`SCTW_BIT_WIDTH])
			|| (old_v[`SCTW_BIT_MODE_FAULT_ENABLE] != new_v[`SCTW_BIT_MODE_FAULT_ENABLE])
			|| (old_v[`SCTW_BIT_PINCTL] != new_v[`SCTW_BIT_PINCTL]);
		oe = old_v[`SCTW_BIT_PINCTL] && (old_v[`SCTW_BIT_BIDIR_OUTPUT_ENABLE] != new_v[`SCTW_BIT_BIDIR_OUTPUT_ENABLE]);
		return base || oe;
	endfunction : cfg_abort

	always_comb begin
		cfg_bus.master = ctrl_one_ff[`SCTW_BIT_MASTER];
		cfg_bus.select_output_enable = ctrl_one_ff[`SCTW_BIT_SELECT_OUTPUT_ENABLE];
		cfg_bus.width = ctrl_two_ff[`SCTW_BIT_WIDTH];
		cfg_bus.mode_fault_enable = ctrl_two_ff[`SCTW_BIT_MODE_FAULT_ENABLE];
		cfg_bus.bidir_oe = ctrl_two_ff[`SCTW_BIT_BIDIR_OUTPUT_ENABLE];
		cfg_bus.wait_stop = ctrl_two_ff[`SCTW_BIT_WAITSTOP];
		cfg_bus.pinctl = ctrl_two_ff[`SCTW_BIT_PINCTL];
		cfg_bus.wait_mode = i_wait_mode;
	end

	// select pin and done toggle come from outside this clock
	sctw_sync #(.W(1)) u_ss_sync (
		.i_clk(i_clk),
		.i_rst(i_sys_rst),
		.i_d(i_ss_n),
		.o_q(ss_n_bus)
	);
	sctw_sync #(.W(1)) u_done_sync (
		.i_clk(i_clk),
		.i_rst(i_sys_rst),
		.i_d(done_tgl_lk_ff),
		.o_q(done_tgl_bus)
	);

	// ------------------------------------------------------------
	// register port and transfer control
	// ------------------------------------------------------------
	always_comb begin
		logic wr_one, wr_two, wr_hi, wr_lo, wr_st, done_evt, mode_fault_flag_evt, abort;
		wr_one = i_wr && (i_addr == `SCTW_OFS_CTRL_ONE);
		wr_two = i_wr && (i_addr == `SCTW_OFS_CTRL_TWO);
		wr_hi = i_wr && (i_addr == `SCTW_OFS_DATA_HI);
		wr_lo = i_wr && (i_addr == `SCTW_OFS_DATA_LO);
		wr_st = i_wr && (i_addr == `SCTW_OFS_STATUS);
		done_evt = done_tgl_bus != done_seen_ff;
		nxt_ctrl_one = ctrl_one_ff;
		nxt_ctrl_two = ctrl_two_ff;
		nxt_data_hi = data_hi_ff;
		nxt_data_lo = data_lo_ff;
		nxt_tx = tx_ff;
		nxt_busy = busy_ff;
		nxt_done_flag = done_flag_ff;
		nxt_mode_fault_flag = mode_fault_flag_ff;
		nxt_start_tgl = start_tgl_ff;
		nxt_abort_tgl = abort_tgl_ff;
		nxt_done_seen = done_tgl_bus;
		abort = 1'b0;
		// fault detection only with the select pin as input under fault enable
		mode_fault_flag_evt = cfg_bus.master && cfg_bus.mode_fault_enable && !cfg_bus.select_output_enable && !ss_n_bus;
		if (wr_one) begin
			nxt_ctrl_one = i_wdata & `SCTW_CTRL_ONE_MASK;
			if (nxt_ctrl_one != ctrl_one_ff) begin
				abort = 1'b1;
			end
		end
		if (wr_two) begin
			nxt_ctrl_two = i_wdata & `SCTW_CTRL_TWO_MASK;
			if (cfg_bus.master && cfg_abort(ctrl_two_ff, nxt_ctrl_two)) begin
				abort = 1'b1;
			end
		end
		if (mode_fault_flag_evt) begin
			abort = 1'b1;
			nxt_ctrl_one[`SCTW_BIT_MASTER] = 1'b0;
		end
		if (wr_hi && !busy_ff) begin
			nxt_data_hi = i_wdata;
		end
		if (wr_st) begin
			if (i_wdata[`SCTW_BIT_DONE]) begin
				nxt_done_flag = 1'b0;
			end
			if (i_wdata[`SCTW_BIT_MODE_FAULT_FLAG]) begin
				nxt_mode_fault_flag = 1'b0;
			end
		end
		// a low byte write starts the transfer; 16-bit takes both bytes
		if (wr_lo && !busy_ff && !abort) begin
			nxt_data_lo = i_wdata;
			nxt_tx = cfg_bus.width ? {data_hi_ff, i_wdata} : {8'h00, i_wdata};
			nxt_busy = 1'b1;
			nxt_start_tgl = !start_tgl_ff;
		end
		if (done_evt && busy_ff) begin
			nxt_busy = 1'b0;
			nxt_done_flag = 1'b1;
			nxt_data_lo = rx_bus[7:0];
			nxt_data_hi = cfg_bus.width ? rx_bus[15:8] : data_hi_ff;
		end
		if (mode_fault_flag_evt) begin
			nxt_mode_fault_flag = 1'b1;
		end
		if (abort && busy_ff) begin
			nxt_busy = 1'b0;
			nxt_abort_tgl = !abort_tgl_ff;
		end
		nxt_rdata = 8'h00;
		if (i_rd) begin
			unique case (i_addr)
				`SCTW_OFS_CTRL_ONE: nxt_rdata = ctrl_one_ff;
				`SCTW_OFS_CTRL_TWO: nxt_rdata = ctrl_two_ff;
				`SCTW_OFS_STATUS: begin
					nxt_rdata[`SCTW_BIT_DONE] = done_flag_ff;
					nxt_rdata[`SCTW_BIT_MODE_FAULT_FLAG] = mode_fault_flag_ff;
					nxt_rdata[`SCTW_BIT_BUSY] = busy_ff;
				end
				`SCTW_OFS_DATA_HI: nxt_rdata = cfg_bus.width ? data_hi_ff : 8'h00;
				`SCTW_OFS_DATA_LO: nxt_rdata = data_lo_ff;
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ctrl_one_ff <= `SCTW_RST_CTRL_ONE;
			ctrl_two_ff <= `SCTW_RST_CTRL_TWO;
			data_hi_ff <= 8'h00;
			data_lo_ff <= 8'h00;
			tx_ff <= 16'h0000;
			busy_ff <= 1'b0;
			done_flag_ff <= 1'b0;
			mode_fault_flag_ff <= 1'b0;
			start_tgl_ff <= 1'b0;
			abort_tgl_ff <= 1'b0;
			done_seen_ff <= 1'b0;
			rdata_ff <= 8'h00;
		end else begin
			ctrl_one_ff <= nxt_ctrl_one;
			ctrl_two_ff <= nxt_ctrl_two;
			data_hi_ff <= nxt_data_hi;
			data_lo_ff <= nxt_data_lo;
			tx_ff <= nxt_tx;
			busy_ff <= nxt_busy;
			done_flag_ff <= nxt_done_flag;
			mode_fault_flag_ff <= nxt_mode_fault_flag;
			start_tgl_ff <= nxt_start_tgl;
			abort_tgl_ff <= nxt_abort_tgl;
			done_seen_ff <= nxt_done_seen;
			rdata_ff <= nxt_rdata;
		end
	end

	assign o_rdata = rdata_ff;

	// ------------------------------------------------------------
	// crossing into the link domain
	// ------------------------------------------------------------
	// config bits are quasi-static; any change that matters also aborts, except second control register changes in slave mode
	logic lk_rst;
	sctw_pkg::cfg_type cfg_lk;
	logic start_tgl_lk, abort_tgl_lk;

	sctw_sync #(.W(1)) u_rst_sync (
		.i_clk(i_link_clk),
		.i_rst(1'b0),
		.i_d(i_sys_rst),
		.o_q(lk_rst)
	);
	sctw_sync #(.W(10)) u_cfg_sync (
		.i_clk(i_link_clk),
		.i_rst(lk_rst),
		.i_d({cfg_bus, start_tgl_ff, abort_tgl_ff}),
		.o_q({cfg_lk, start_tgl_lk, abort_tgl_lk})
	);

	// ------------------------------------------------------------
	// link domain shift engine
	// ------------------------------------------------------------
	sctw_pkg::state_type st_ff, nxt_st;
	logic [4:0] cnt_ff, nxt_cnt;
	logic [15:0] sh_ff, nxt_sh;
	logic [15:0] rx_ff, nxt_rx;
	logic phase_ff, nxt_phase;
	logic samp_ff, nxt_samp;
	logic nxt_done_tgl_lk;
	logic start_seen_ff, nxt_start_seen;
	logic abort_seen_ff, nxt_abort_seen;
	sctw_pkg::pin_out_type pins_ff, nxt_pins;

	// rx is stable from the done toggle until the next start
	assign rx_bus = rx_ff;

	always_comb begin
		logic [4:0] nbits;
		logic din, dout, freeze, last;
		logic [15:0] shifted;
		nbits = cfg_lk.width ? `SCTW_WIDTH_WIDE : `SCTW_WIDTH_NARROW;
		dout = cfg_lk.width ? sh_ff[15] : sh_ff[7];
		// pin that carries incoming data for each wiring
		if (cfg_lk.master) begin
			din = cfg_lk.pinctl ? i_mosi : i_miso;
		end else begin
			din = cfg_lk.pinctl ? i_miso : i_mosi;
		end
		freeze = cfg_lk.master && cfg_lk.wait_mode && cfg_lk.wait_stop;
		last = (cnt_ff == nbits - 5'h01);
		shifted = {sh_ff[14:0], din};
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_sh = sh_ff;
		nxt_rx = rx_ff;
		nxt_phase = phase_ff;
		nxt_samp = samp_ff;
		nxt_done_tgl_lk = done_tgl_lk_ff;
		nxt_start_seen = start_tgl_lk;
		nxt_abort_seen = abort_tgl_lk;
		unique case (st_ff)
			sctw_pkg::ST_IDLE: begin
				nxt_phase = 1'b0;
				nxt_cnt = 5'h00;
				if (start_tgl_lk != start_seen_ff) begin
					nxt_sh = tx_ff;
					nxt_st = sctw_pkg::ST_SHIFT;
				end
			end
			sctw_pkg::ST_SHIFT: begin
				if (cfg_lk.master) begin
					// leading half samples, trailing half shifts
					if (!freeze) begin
						nxt_phase = !phase_ff;
						if (!phase_ff) begin
							nxt_samp = din;
						end else begin
							nxt_sh = {sh_ff[14:0], samp_ff};
							nxt_cnt = cnt_ff + 5'h01;
							if (last) begin
								nxt_rx = {sh_ff[14:0], samp_ff};
							end
						end
					end
				end else if (!i_ss_n) begin
					// slave: link clock is the master's serial clock
					nxt_sh = shifted;
					nxt_cnt = cnt_ff + 5'h01;
					if (last) begin
						nxt_rx = shifted;
					end
				end
				if (last && (!cfg_lk.master || phase_ff) && !(cfg_lk.master && freeze)) begin
					nxt_done_tgl_lk = !done_tgl_lk_ff;
					nxt_st = sctw_pkg::ST_IDLE;
				end
			end
			default: nxt_st = sctw_pkg::ST_IDLE;
		endcase
		if (abort_tgl_lk != abort_seen_ff) begin
			nxt_st = sctw_pkg::ST_IDLE;
			nxt_phase = 1'b0;
		end
		// pin drive for the next cycle
		nxt_pins.sck = cfg_lk.master && (nxt_st == sctw_pkg::ST_SHIFT) && nxt_phase;
		nxt_pins.mosi_o = dout;
		nxt_pins.miso_o = dout;
		if (cfg_lk.master) begin
			nxt_pins.mosi_oe = cfg_lk.pinctl ? cfg_lk.bidir_oe : 1'b1;
			nxt_pins.miso_oe = 1'b0;
		end else begin
			nxt_pins.mosi_oe = 1'b0;
			nxt_pins.miso_oe = (cfg_lk.pinctl ? cfg_lk.bidir_oe : 1'b1) && !i_ss_n;
		end
		// select pin is output only with fault enable and output enable
		nxt_pins.ss_oe = cfg_lk.master && cfg_lk.mode_fault_enable && cfg_lk.select_output_enable;
		nxt_pins.ss_o = !(nxt_st == sctw_pkg::ST_SHIFT);
	end

	always_ff @(posedge i_link_clk) begin
		if (lk_rst) begin
			st_ff <= sctw_pkg::ST_IDLE;
			cnt_ff <= 5'h00;
			sh_ff <= 16'h0000;
			rx_ff <= 16'h0000;
			phase_ff <= 1'b0;
			samp_ff <= 1'b0;
			done_tgl_lk_ff <= 1'b0;
			start_seen_ff <= 1'b0;
			abort_seen_ff <= 1'b0;
			pins_ff <= '0;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			rx_ff <= nxt_rx;
			phase_ff <= nxt_phase;
			samp_ff <= nxt_samp;
			done_tgl_lk_ff <= nxt_done_tgl_lk;
			start_seen_ff <= nxt_start_seen;
			abort_seen_ff <= nxt_abort_seen;
			pins_ff <= nxt_pins;
		end
	end

	assign o_pins = pins_ff;
endmodule : sctw_ctrl

/* sim/sctw_ctrl_checker.sv */
// sctw_ctrl_checker: port properties of the serial control block
// assumes: bound to sctw_ctrl; bus strobes never overlap
`timescale 1ns/100ps
module sctw_ctrl_checker (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic i_wait_mode,
	input wire logic i_link_clk,
	input wire logic i_ss_n,
	input wire sctw_pkg::pin_out_type o_pins
);
	// shadows of the control bits; calm waits out the sync lag after changes
	logic [7:0] c1_ff;
	logic [7:0] c2_ff;
	logic [4:0] calm_ff;
	wire ms = c1_ff[4];
	wire calm = calm_ff == 5'h18;
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_wr || $changed(i_wait_mode) || $changed(i_ss_n)) begin
			calm_ff <= 5'h00;
		end else if (!calm) begin
			calm_ff <= calm_ff + 5'h01;
		end
		if (i_sys_rst) begin
			c1_ff <= 8'h00;
			c2_ff <= 8'h00;
		end else if (i_wr && i_addr == 8'h00) begin
			c1_ff <= i_wdata & 8'h12;
		end else if (i_wr && i_addr == 8'h01) begin
			c2_ff <= i_wdata & 8'h5b;
		end
	end
	rd_back_a:
		assert property (@(posedge i_clk) disable iff (i_sys_rst)
			$past(i_rd && i_addr == 8'h01) |-> o_rdata == $past(c2_ff)) else $error("ctrl readback");
	hi_unused_a:
		assert property (@(posedge i_clk) disable iff (i_sys_rst)
			$past(i_rd && i_addr == 8'h04 && !c2_ff[6]) |-> o_rdata == 8'h00) else $error("high byte");
	ss_off_a:
		assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
			calm && ms && !c2_ff[4] |-> !o_pins.ss_oe) else $error("select pin used");
	ss_in_a:
		assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
			calm && !ms |-> !o_pins.ss_oe) else $error("slave drives select");
	ss_out_a:
		assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
			calm && ms && c2_ff[4] && c1_ff[1] |-> o_pins.ss_oe) else $error("select not driven");
	miso_quiet_a:
		assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
			calm && ms |-> !o_pins.miso_oe) else $error("master drives miso");
	mosi_gate_a:
		assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
			calm && ms && c2_ff[0] |-> o_pins.mosi_oe == c2_ff[3]) else $error("mosi gate");
	mosi_quiet_a:
		assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
			calm && !ms && c2_ff[0] |-> !o_pins.mosi_oe) else $error("slave drives mosi");
	sck_hold_a:
		assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
			calm && ms && c2_ff[1] && i_wait_mode |=> $stable(o_pins.sck)) else $error("sck runs");
endmodule : sctw_ctrl_checker

/* sim/sctw_far_slave.sv */
// sctw_far_slave: far-side slave, separate transmit and receive shift registers, msb first
// assumes: sck idles low, master changes data on the falling edge
`timescale 1ns/100ps
module sctw_far_slave (
	input wire logic i_sck,
	input wire logic i_sel,
	input wire logic i_mosi,
	input wire logic i_load,
	input wire logic [15:0] i_tx,
	output logic o_miso,
	output logic [15:0] o_rx
);
	logic [15:0] sh = 16'h0000;
	// unselected: show the inverse so a stale bit never passes
	assign o_miso = i_sel ? sh[15] : ~sh[15];
	always @(posedge i_sck) begin
		if (i_sel) begin
			o_rx <= {o_rx[14:0], i_mosi};
		end
	end
	always @(negedge i_sck or posedge i_load) begin
		if (i_load) begin
			sh <= i_tx;
		end else if (i_sel) begin
			sh <= {sh[14:0], 1'b0};
		end
	end
endmodule : sctw_far_slave

/* sim/tb_top.sv */
// tb_top: register, pin, transfer, abort, wait and fault tests of sctw_ctrl
// assumes: 50 MHz bus clock, 30 ns link clock, far slave model attached
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
	begin \
		tests_run++; \
		if ((got) !== (ex)) begin \
			errors++; \
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
		end \
	end
module tb_top;
	logic i_clk, i_link_clk, i_sys_rst, i_wr, i_rd, i_wait_mode, ss_n, load, miso;
	logic [7:0] i_addr, i_wdata, o_rdata, rv;
	logic [15:0] ptx, prx, d;
	sctw_pkg::pin_out_type pins;
	int errors = 0, tests_run = 0, seed = 86, n;
	logic [15:0] cfg [8] = '{16'h1000, 16'h1010, 16'h1210, 16'h1001, 16'h1009, 16'h0000,
		16'h0201, 16'h0009};
	logic [15:0] ab [6] = '{16'h4000, 16'h0010, 16'h0001, 16'h0901, 16'h0002, 16'h0008};
	sctw_ctrl DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_wait_mode(i_wait_mode),
		.i_link_clk(i_link_clk), .i_miso(miso), .i_mosi(pins.mosi_oe ? pins.mosi_o : 1'b1),
		.i_ss_n(ss_n), .o_pins(pins));
	sctw_far_slave u_far (.i_sck(pins.sck), .i_sel(pins.ss_oe ? !pins.ss_o : 1'b1),
		.i_mosi(pins.mosi_o), .i_load(load), .i_tx(ptx), .o_miso(miso), .o_rx(prx));
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	initial begin
		i_link_clk = 1'b0;
		#7;
		forever #15 i_link_clk = ~i_link_clk;
	end
	function automatic logic abort_exp(input logic [15:0] c);
		return ((c[15:8] ^ c[7:0]) & 8'h51) != 8'h00 || (c[8] && c[0] && (c[11] ^ c[3]));
	endfunction : abort_exp
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] ex);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		rv = o_rdata;
		@(posedge i_clk);
		`CHK($sformatf("reg %h", a), ex, rv & m)
	endtask : rchk
	task automatic go(input logic w);
		d = 16'($random(seed));
		ptx = 16'($random(seed));
		load <= 1'b1;
		@(posedge i_clk);
		load <= 1'b0;
		if (w) wr(8'h04, d[15:8]);
		wr(8'h05, d[7:0]);
	endtask : go
	task automatic done_chk(input logic w);
		n = 0;
		rv = 8'h01;
		while (rv[0] !== 1'b0 && n < 60) begin
			i_addr <= 8'h03;
			i_rd <= 1'b1;
			@(posedge i_clk);
			i_rd <= 1'b0;
			@(negedge i_clk);
			rv = o_rdata;
			@(posedge i_clk);
			n++;
		end
		rchk(8'h03, 8'h81, 8'h80);
		rchk(8'h05, 8'hff, w ? ptx[7:0] : ptx[15:8]);
		rchk(8'h04, 8'hff, w ? ptx[15:8] : 8'h00);
		`CHK("far rx", w ? d : {8'h00, d[7:0]}, w ? prx : {8'h00, prx[7:0]})
		wr(8'h03, 8'h80);
	endtask : done_chk
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (20000) @(posedge i_clk);
		errors++;
		print_verdict();
	end
	initial begin
		{i_sys_rst, i_wr, i_rd, i_wait_mode, load, ss_n} = 6'h21;
		{i_addr, i_wdata, ptx} = 32'h0;
		repeat (6) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		repeat (20) @(posedge i_clk);
		rchk(8'h01, 8'hff, 8'h00);
		rchk(8'h04, 8'hff, 8'h00);
		wr(8'h01, 8'hff);
		rchk(8'h01, 8'hff, 8'h5b);
		wr(8'h07, 8'h5a);
		rchk(8'h07, 8'hff, 8'h00);
		for (int i = 0; i < 6; i++) begin
			d = 16'($random(seed));
			wr(8'h01, d[7:0]);
			rchk(8'h01, 8'hff, d[7:0] & 8'h5b);
		end
		$display("test registers ended");
		foreach (cfg[i]) begin
			wr(8'h00, cfg[i][15:8]);
			wr(8'h01, cfg[i][7:0]);
			repeat (30) @(posedge i_clk);
			`CHK("select oe", cfg[i][12] & cfg[i][4] & cfg[i][9], pins.ss_oe)
			if (cfg[i][12] && cfg[i][0]) `CHK("data oe", cfg[i][3], pins.mosi_oe)
		end
		$display("test pins ended");
		for (int i = 0; i < 6; i++) begin
			wr(8'h00, i > 3 ? 8'h12 : 8'h10);
			wr(8'h01, {1'b0, i[0], 1'b0, i > 3, 4'h0});
			go(i[0]);
			done_chk(i[0]);
		end
		$display("test transfers ended");
		wr(8'h00, 8'h10);
		foreach (ab[i]) begin
			wr(8'h01, ab[i][15:8]);
			go(ab[i][14]);
			repeat (12) @(posedge i_clk);
			wr(8'h01, ab[i][7:0]);
			if (abort_exp(ab[i])) rchk(8'h03, 8'h81, 8'h00);
			else done_chk(ab[i][14]);
			wr(8'h01, 8'h00);
		end
		$display("test aborts ended");
		wr(8'h01, 8'h02);
		i_wait_mode <= 1'b1;
		go(1'b0);
		repeat (60) @(posedge i_clk);
		rchk(8'h03, 8'h01, 8'h01);
		i_wait_mode <= 1'b0;
		done_chk(1'b0);
		wr(8'h01, 8'h00);
		i_wait_mode <= 1'b1;
		go(1'b0);
		done_chk(1'b0);
		i_wait_mode <= 1'b0;
		$display("test wait ended");
		wr(8'h01, 8'h10);
		ss_n <= 1'b0;
		repeat (14) @(posedge i_clk);
		ss_n <= 1'b1;
		rchk(8'h03, 8'h10, 8'h10);
		rchk(8'h00, 8'h10, 8'h00);
		i_sys_rst <= 1'b1;
		repeat (6) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		repeat (20) @(posedge i_clk);
		rchk(8'h01, 8'hff, 8'h00);
		rchk(8'h03, 8'h91, 8'h00);
		$display("test fault and reset ended");
		print_verdict();
	end
endmodule : tb_top
bind sctw_ctrl sctw_ctrl_checker u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_wait_mode(i_wait_mode),
	.i_link_clk(i_link_clk), .i_ss_n(i_ss_n), .o_pins(o_pins));
